/* rtl/pcn_pkg.sv */
// Package: constants, register map and state types of the pin change interrupt block
package pcn_pkg;

    // Ports of eight pins each
    localparam int NUM_PORTS = 4;
    localparam int PORT_W = 8;
    localparam int PINS = NUM_PORTS * PORT_W;

    // Register byte offsets
    localparam logic [7:0] OFS_RISE_EN = 8'h00;
    localparam logic [7:0] OFS_FALL_EN = 8'h10;
    localparam logic [7:0] OFS_FLAG = 8'h20;
    localparam logic [7:0] OFS_CORE_CTRL = 8'h30;
    localparam logic [7:0] OFS_EVT_STATUS = 8'h34;
    localparam logic [7:0] OFS_EVT_CLEAR = 8'h38;
    localparam logic [7:0] OFS_EVT_ENABLE = 8'h3c;
    localparam logic [7:0] OFS_BANK_MASK = 8'hf0;

    // Core control fields
    localparam int CTRL_MASTER_EN_BIT = 0;
    localparam int CTRL_SUMMARY_BIT = 1;

    // Reset values
    localparam logic [PINS-1:0] RST_PINS = 32'h0000_0000;
    localparam logic [NUM_PORTS-1:0] RST_EVT = 4'h0;

    // Bus responses
    localparam logic [1:0] RESP_OKAY = 2'h0;
    localparam logic [1:0] RESP_SLVERR = 2'h2;

    typedef struct packed {
        logic [7:0] awaddr;
        logic awvalid;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic wvalid;
        logic bready;
        logic [7:0] araddr;
        logic arvalid;
        logic rready;
    } pcn_axi_req_type;

    typedef struct packed {
        logic awready;
        logic wready;
        logic [1:0] bresp;
        logic bvalid;
        logic arready;
        logic [31:0] rdata;
        logic [1:0] rresp;
        logic rvalid;
    } pcn_axi_rsp_type;

    typedef struct packed {
        logic [PINS-1:0] sync1;
        logic [PINS-1:0] sync2;
        logic [PINS-1:0] prev;
        logic [PINS-1:0] rise_en;
        logic [PINS-1:0] fall_en;
        logic [PINS-1:0] flag;
        logic master_en;
        logic [NUM_PORTS-1:0] evt_status;
        logic [NUM_PORTS-1:0] evt_en;
        logic aw_have;
        logic [7:0] aw_addr;
        logic w_have;
        logic [31:0] wdata;
        logic [3:0] wstrb;
        logic bvalid;
        logic [1:0] bresp;
        logic rvalid;
        logic [31:0] rdata;
        logic [1:0] rresp;
    } pcn_state_type;

endpackage

/* rtl/pcn_top.sv */
// Pin change interrupt block with AXI4-Lite register slave
`timescale 1ns/100ps
`default_nettype none

module pcn_top (
    // Clock and reset
    input wire logic clk,
    input wire logic rst,
    // Port pins
    input wire logic [pcn_pkg::PINS-1:0] pins,
    // Register bus
    input wire pcn_pkg::pcn_axi_req_type axi_req,
    output pcn_pkg::pcn_axi_rsp_type axi_rsp,
    // Core requests
    output logic change_irq,
    output logic wake_req,
    output logic summary_flag,
    output logic irq
);

    ////////////////////////////////////////////////////////////////////////////////
    // State

    pcn_pkg::pcn_state_type st_q;
    pcn_pkg::pcn_state_type st_d;
    logic [pcn_pkg::PINS-1:0] edge_hit;
    logic [pcn_pkg::PINS-1:0] rise_seen;
    logic [pcn_pkg::PINS-1:0] fall_seen;
    logic [pcn_pkg::NUM_PORTS-1:0] port_hit;
    logic do_write;
    logic flag_wr;

    // Byte lane of one port within a pin vector
    function automatic logic [pcn_pkg::PINS-1:0] lane_mask(input logic [1:0] port);
        lane_mask = {{(pcn_pkg::PINS-pcn_pkg::PORT_W){1'b0}}, 8'hff} << (port * 8);
    endfunction

    // Register read, also used to flag unmapped addresses
    function automatic logic [32:0] reg_read(input pcn_pkg::pcn_state_type s,
                                             input logic [7:0] addr);
        logic [4:0] sh;
        logic [32:0] r;
        sh = {addr[3:2], 3'h0};
        r = {1'b0, 32'h0000_0000};
        case (addr & pcn_pkg::OFS_BANK_MASK)
            pcn_pkg::OFS_RISE_EN: r = {1'b0, 24'h00_0000, 8'(s.rise_en >> sh)};
            pcn_pkg::OFS_FALL_EN: r = {1'b0, 24'h00_0000, 8'(s.fall_en >> sh)};
            pcn_pkg::OFS_FLAG: r = {1'b0, 24'h00_0000, 8'(s.flag >> sh)};
            default: begin
                case (addr)
                    pcn_pkg::OFS_CORE_CTRL: r = {1'b0, 30'h0000_0000, |s.flag, s.master_en};
                    pcn_pkg::OFS_EVT_STATUS: r = {1'b0, 28'h000_0000, s.evt_status};
                    pcn_pkg::OFS_EVT_CLEAR: r = {1'b0, 32'h0000_0000};
                    pcn_pkg::OFS_EVT_ENABLE: r = {1'b0, 28'h000_0000, s.evt_en};
                    default: r = {1'b1, 32'h0000_0000};
                endcase
            end
        endcase
        if (addr[1:0] != 2'h0) begin
            r = {1'b1, 32'h0000_0000};
        end
        reg_read = r;
    endfunction

    ////////////////////////////////////////////////////////////////////////////////
    // Edge detection

    always_comb begin
        rise_seen = st_q.sync2 & ~st_q.prev;
        fall_seen = ~st_q.sync2 & st_q.prev;
        edge_hit = (rise_seen & st_q.rise_en) | (fall_seen & st_q.fall_en);
        for (int p = 0; p < pcn_pkg::NUM_PORTS; p++) begin
            port_hit[p] = |(edge_hit & lane_mask(2'(p)));
        end
    end

    assign do_write = st_q.aw_have && st_q.w_have && !st_q.bvalid;
    assign flag_wr = do_write && st_q.wstrb[0]
        && ((st_q.aw_addr & pcn_pkg::OFS_BANK_MASK) == pcn_pkg::OFS_FLAG)
        && (st_q.aw_addr[1:0] == 2'h0);

    ////////////////////////////////////////////////////////////////////////////////
    // Next state

    always_comb begin
        logic [pcn_pkg::PINS-1:0] lane;
        logic [pcn_pkg::PINS-1:0] wbyte;
        logic [32:0] rd;
        logic hit;
        st_d = st_q;
        lane = lane_mask(st_q.aw_addr[3:2]);
        wbyte = {{(pcn_pkg::PINS-8){1'b0}}, st_q.wdata[7:0]} << {st_q.aw_addr[3:2], 3'h0};
        rd = reg_read(st_q, axi_req.araddr);
        hit = 1'b1;

        // Two flops before any logic looks at a pin; third holds the last sample
        st_d.sync1 = pins;
        st_d.sync2 = st_q.sync1;
        st_d.prev = st_q.sync2;

        // Hardware set is ORed in last so it wins over a clearing write
        st_d.flag = st_q.flag | edge_hit;
        st_d.evt_status = st_q.evt_status | port_hit;

        // Write address and data may arrive in either order
        if (axi_req.awvalid && !st_q.aw_have && !st_q.bvalid) begin
            st_d.aw_have = 1'b1;
            st_d.aw_addr = axi_req.awaddr;
        end
        if (axi_req.wvalid && !st_q.w_have && !st_q.bvalid) begin
            st_d.w_have = 1'b1;
            st_d.wdata = axi_req.wdata;
            st_d.wstrb = axi_req.wstrb;
        end

        if (do_write) begin
            st_d.aw_have = 1'b0;
            st_d.w_have = 1'b0;
            st_d.bvalid = 1'b1;
            st_d.bresp = pcn_pkg::RESP_OKAY;
            if (st_q.aw_addr[1:0] != 2'h0) begin
                hit = 1'b0;
            end else if (!st_q.wstrb[0]) begin
                // Registers live in byte lane 0; other lanes are ignored
                hit = 1'b1;
            end else begin
                case (st_q.aw_addr & pcn_pkg::OFS_BANK_MASK)
                    pcn_pkg::OFS_RISE_EN: st_d.rise_en = (st_q.rise_en & ~lane) | wbyte;
                    pcn_pkg::OFS_FALL_EN: st_d.fall_en = (st_q.fall_en & ~lane) | wbyte;
                    pcn_pkg::OFS_FLAG: begin
                        st_d.flag = (st_q.flag & ~lane) | wbyte | edge_hit;
                    end
                    default: begin
                        case (st_q.aw_addr)
                            pcn_pkg::OFS_CORE_CTRL: begin
                                st_d.master_en = st_q.wdata[pcn_pkg::CTRL_MASTER_EN_BIT];
                            end
                            pcn_pkg::OFS_EVT_CLEAR: begin
                                st_d.evt_status = (st_q.evt_status & ~st_q.wdata[3:0])
                                    | port_hit;
                            end
                            pcn_pkg::OFS_EVT_ENABLE: st_d.evt_en = st_q.wdata[3:0];
                            pcn_pkg::OFS_EVT_STATUS: hit = 1'b1;
                            default: hit = 1'b0;
                        endcase
                    end
                endcase
            end
            if (!hit) begin
                st_d.bresp = pcn_pkg::RESP_SLVERR;
            end
        end else if (st_q.bvalid && axi_req.bready) begin
            st_d.bvalid = 1'b0;
        end

        if (axi_req.arvalid && !st_q.rvalid) begin
            st_d.rvalid = 1'b1;
            st_d.rdata = rd[31:0];
            st_d.rresp = rd[32] ? pcn_pkg::RESP_SLVERR : pcn_pkg::RESP_OKAY;
        end else if (st_q.rvalid && axi_req.rready) begin
            st_d.rvalid = 1'b0;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Registers

    always_ff @(posedge clk) begin
        if (rst) begin
            st_q <= '0;
        end else begin
            st_q <= st_d;
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    // Outputs

    always_comb begin
        axi_rsp.awready = !st_q.aw_have && !st_q.bvalid;
        axi_rsp.wready = !st_q.w_have && !st_q.bvalid;
        axi_rsp.bresp = st_q.bresp;
        axi_rsp.bvalid = st_q.bvalid;
        axi_rsp.arready = !st_q.rvalid;
        axi_rsp.rdata = st_q.rdata;
        axi_rsp.rresp = st_q.rresp;
        axi_rsp.rvalid = st_q.rvalid;
    end

    // Both requests come from the flag register, so the flag is in place first
    assign summary_flag = |st_q.flag;
    assign change_irq = st_q.master_en && summary_flag;
    assign wake_req = st_q.master_en && summary_flag;
    assign irq = |(st_q.evt_status & st_q.evt_en);

    ////////////////////////////////////////////////////////////////////////////////
    // Checks

    property p_rise_sets_flag;
        @(posedge clk) disable iff (rst)
        (|(rise_seen & st_q.rise_en))
        |=> ((st_q.flag & $past(rise_seen & st_q.rise_en)) == $past(rise_seen & st_q.rise_en));
    endproperty
    a_rise_sets_flag: assert property (p_rise_sets_flag)
        else $error("enabled rising edge did not set flag");

    property p_no_unenabled_edge;
        @(posedge clk) disable iff (rst)
        (edge_hit & ~((rise_seen & st_q.rise_en) | (fall_seen & st_q.fall_en))) == '0;
    endproperty
    a_no_unenabled_edge: assert property (p_no_unenabled_edge)
        else $error("edge detected without its enable");

    property p_both_dirs;
        @(posedge clk) disable iff (rst)
        (|((st_q.sync2 ^ st_q.prev) & st_q.rise_en & st_q.fall_en))
        |=> ((st_q.flag & $past((st_q.sync2 ^ st_q.prev) & st_q.rise_en & st_q.fall_en))
            == $past((st_q.sync2 ^ st_q.prev) & st_q.rise_en & st_q.fall_en));
    endproperty
    a_both_dirs: assert property (p_both_dirs)
        else $error("change with both enables not flagged");

    property p_flag_sticky;
        @(posedge clk) disable iff (rst)
        !flag_wr |=> ((st_q.flag & $past(st_q.flag)) == $past(st_q.flag));
    endproperty
    a_flag_sticky: assert property (p_flag_sticky)
        else $error("flag dropped without a clearing write");

    property p_irq_gated;
        @(posedge clk) disable iff (rst)
        change_irq |-> (st_q.master_en && (st_q.flag != '0));
    endproperty
    a_irq_gated: assert property (p_irq_gated)
        else $error("change request without flag and master enable");

    property p_summary;
        @(posedge clk) disable iff (rst)
        $changed(st_q.flag) |-> (summary_flag == (st_q.flag != '0));
    endproperty
    a_summary: assert property (p_summary)
        else $error("summary flag differs from flag OR");

    property p_set_wins;
        @(posedge clk) disable iff (rst)
        (flag_wr && (edge_hit != '0))
        |=> ((st_q.flag & $past(edge_hit)) == $past(edge_hit));
    endproperty
    a_set_wins: assert property (p_set_wins)
        else $error("edge lost during clearing write");

    property p_wake;
        @(posedge clk) disable iff (rst)
        (st_q.master_en && (edge_hit != '0) && !do_write) |=> wake_req;
    endproperty
    a_wake: assert property (p_wake)
        else $error("enabled edge did not raise wake");

    property p_pin_to_flag;
        @(posedge clk) disable iff (rst)
        ($rose(pins[0]) && st_q.rise_en[0] && !do_write) ##1 (st_q.rise_en[0] && !do_write)
        ##1 (st_q.rise_en[0] && !do_write && pins[0]) |=> st_q.flag[0];
    endproperty
    a_pin_to_flag: assert property (p_pin_to_flag)
        else $error("pin edge not flagged three cycles later");

    property p_reset_clears;
        @(posedge clk)
        rst |=> ((st_q.rise_en == '0) && (st_q.fall_en == '0) && (st_q.flag == '0)
            && !st_q.master_en && !change_irq);
    endproperty
    a_reset_clears: assert property (p_reset_clears)
        else $error("reset left an enable or flag set");

    property p_master_off;
        @(posedge clk) disable iff (rst)
        (!st_q.master_en && !do_write) |=> !change_irq;
    endproperty
    a_master_off: assert property (p_master_off)
        else $error("change request raised with master enable clear");

    // Port event must survive a clear that lands on the same edge
    property p_evt_sets;
        @(posedge clk) disable iff (rst)
        (port_hit != '0) |=> ((st_q.evt_status & $past(port_hit)) == $past(port_hit));
    endproperty
    a_evt_sets: assert property (p_evt_sets)
        else $error("port edge did not set event status");

endmodule

`default_nettype wire

/* testbench/pcn_pin_model.sv */
// Outside drivers of the port pins, standing in for the board
`timescale 1ns/100ps
`default_nettype none

module pcn_pin_model (
    // Clock
    input wire logic clk,
    // Requested and driven levels
    input wire logic [pcn_pkg::PINS-1:0] want,
    output logic [pcn_pkg::PINS-1:0] pins
);
    ////////////////////////////////////////////////////////////////////////////////
    logic [pcn_pkg::PINS-1:0] pins_q;

    // Levels move one edge after the request, so the bench never races the synchroniser
    always_ff @(posedge clk) begin
        pins_q <= want;
    end
    assign pins = pins_q;
endmodule

`default_nettype wire

/* testbench/tb.sv */
// Self-checking bench for the pin change interrupt block
`timescale 1ns/100ps
`default_nettype none

module tb;
    localparam logic [7:0] RIS = pcn_pkg::OFS_RISE_EN;
    localparam logic [7:0] FAL = pcn_pkg::OFS_FALL_EN;
    localparam logic [7:0] FLG = pcn_pkg::OFS_FLAG;
    localparam logic [7:0] CTL = pcn_pkg::OFS_CORE_CTRL;
    localparam logic [7:0] EST = pcn_pkg::OFS_EVT_STATUS;
    localparam logic [7:0] ECL = pcn_pkg::OFS_EVT_CLEAR;
    localparam logic [7:0] EEN = pcn_pkg::OFS_EVT_ENABLE;
    logic clk;
    logic rst;
    logic [pcn_pkg::PINS-1:0] pin_want;
    logic [pcn_pkg::PINS-1:0] pins;
    pcn_pkg::pcn_axi_req_type req;
    pcn_pkg::pcn_axi_rsp_type rsp;
    logic change_irq;
    logic wake_req;
    logic summary_flag;
    logic irq;
    logic [31:0] rd;
    logic [31:0] seen;
    logic [1:0] rs;
    int mismatches = 0;
    int n_compared = 0;
    int cyc = 0;

    ////////////////////////////////////////////////////////////////////////////////
    pcn_pin_model pin_u (.clk(clk), .want(pin_want), .pins(pins));
    pcn_top dut_u (.clk(clk), .rst(rst), .pins(pins), .axi_req(req), .axi_rsp(rsp),
        .change_irq(change_irq), .wake_req(wake_req), .summary_flag(summary_flag), .irq(irq));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    // Bus waits are open-ended; this ceiling is what cuts a hang short
    always @(posedge clk) begin
        cyc <= cyc + 1;
        if (cyc == 4000) begin
            mismatches++;
            end_sim();
        end
    end

    ////////////////////////////////////////////////////////////////////////////////
    task automatic end_sim();
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("[ PASS ]");
        end else begin
            $display("[ FAIL ]");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        n_compared++;
        if (got !== exp) begin
            mismatches++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic axi_wr(input logic [7:0] a, input logic [31:0] d);
        bit aw;
        bit w;
        bit b;
        aw = 0;
        w = 0;
        b = 0;
        @(posedge clk);
        req.awaddr <= a;
        req.awvalid <= 1'b1;
        req.wdata <= d;
        req.wstrb <= 4'hf;
        req.wvalid <= 1'b1;
        req.bready <= 1'b1;
        while (!b) begin
            @(posedge clk);
            if (!aw && rsp.awready) begin
                aw = 1;
                req.awvalid <= 1'b0;
            end
            if (!w && rsp.wready) begin
                w = 1;
                req.wvalid <= 1'b0;
            end
            if (rsp.bvalid) begin
                b = 1;
                rs = rsp.bresp;
                req.bready <= 1'b0;
            end
        end
    endtask

    task automatic axi_rd(input logic [7:0] a);
        bit ar;
        bit r;
        ar = 0;
        r = 0;
        @(posedge clk);
        req.araddr <= a;
        req.arvalid <= 1'b1;
        req.rready <= 1'b1;
        while (!r) begin
            @(posedge clk);
            if (!ar && rsp.arready) begin
                ar = 1;
                req.arvalid <= 1'b0;
            end
            if (rsp.rvalid) begin
                r = 1;
                rd = rsp.rdata;
                rs = rsp.rresp;
                req.rready <= 1'b0;
            end
        end
    endtask

    task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp);
        axi_rd(a);
        chk(rd, exp);
    endtask

    // Pin to flag takes four edges here; six leaves margin
    task automatic drive_pins(input logic [31:0] v);
        @(posedge clk);
        pin_want <= v;
        repeat (6) @(posedge clk);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    task automatic t_reset_vals();
        for (int p = 0; p < 4; p++) begin
            rd_chk(RIS + 8'(4 * p), 32'h0);
            rd_chk(FAL + 8'(4 * p), 32'h0);
            rd_chk(FLG + 8'(4 * p), 32'h0);
        end
        rd_chk(CTL, 32'h0);
        rd_chk(EST, 32'h0);
        rd_chk(EEN, 32'h0);
        chk(32'({change_irq, wake_req, summary_flag, irq}), 32'h0);
    endtask

    task automatic t_edges();
        axi_wr(RIS, 32'h05);
        axi_wr(FAL, 32'h06);
        axi_wr(RIS + 8'h0c, 32'h80);
        drive_pins(32'h8000_000f);
        rd_chk(FLG, 32'h05);
        rd_chk(FLG + 8'h0c, 32'h80);
        drive_pins(32'h0);
        rd_chk(FLG, 32'h07);
        rd_chk(FLG + 8'h04, 32'h0);
        chk(32'({summary_flag, change_irq}), 32'h2);
        rd_chk(CTL, 32'h02);
    endtask

    task automatic t_event();
        rd_chk(EST, 32'h9);
        chk(32'(irq), 32'h0);
        axi_wr(EEN, 32'h1);
        chk(32'(irq), 32'h1);
        axi_wr(EEN, 32'h0);
        chk(32'(irq), 32'h0);
        axi_wr(ECL, 32'h9);
        rd_chk(EST, 32'h0);
        rd_chk(ECL, 32'h0);
        axi_wr(EEN, 32'hf);
        chk(32'(irq), 32'h0);
    endtask

    task automatic t_clear();
        axi_rd(FLG);
        seen = rd;
        axi_wr(RIS, 32'h15);
        drive_pins(32'h10);
        axi_rd(FLG);
        axi_wr(FLG, rd & ~seen);
        rd_chk(FLG, 32'h10);
        axi_wr(FLG + 8'h0c, 32'h0);
        rd_chk(FLG + 8'h0c, 32'h0);
        // Write of zero lands on the edge that sets the flag
        @(posedge clk);
        pin_want <= 32'h8000_0010;
        @(posedge clk);
        axi_wr(FLG + 8'h0c, 32'h0);
        repeat (4) @(posedge clk);
        rd_chk(FLG + 8'h0c, 32'h80);
        axi_wr(FLG + 8'h0c, 32'h0);
        axi_wr(FLG, 32'h0);
        chk(32'(summary_flag), 32'h0);
    endtask

    task automatic t_master();
        axi_wr(RIS + 8'h04, 32'h01);
        axi_wr(CTL, 32'h1);
        chk(32'(change_irq), 32'h0);
        @(posedge clk);
        pin_want <= 32'h8000_0110;
        repeat (3) @(posedge clk);
        #1 chk(32'({change_irq, wake_req}), 32'h0);
        @(posedge clk);
        #1 chk(32'({change_irq, wake_req, summary_flag}), 32'h7);
        rd_chk(FLG + 8'h04, 32'h01);
        rd_chk(CTL, 32'h03);
        axi_wr(CTL, 32'h0);
        chk(32'({change_irq, summary_flag}), 32'h1);
    endtask

    task automatic t_bus();
        axi_rd(8'h40);
        chk(rd, 32'h0);
        chk(32'(rs), 32'(pcn_pkg::RESP_SLVERR));
        axi_wr(8'h44, 32'hff);
        chk(32'(rs), 32'(pcn_pkg::RESP_SLVERR));
        axi_wr(FLG + 8'h04, 32'h0);
        axi_wr(CTL, 32'h2);
        rd_chk(CTL, 32'h0);
    endtask

    ////////////////////////////////////////////////////////////////////////////////
    initial begin
        req = '0;
        rst = 1'b1;
        pin_want = '0;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset_vals();
        t_edges();
        t_event();
        t_clear();
        t_master();
        t_bus();
        axi_wr(FAL + 8'h08, 32'hff);
        axi_wr(CTL, 32'h1);
        axi_wr(FLG + 8'h08, 32'h01);
        chk(32'({change_irq, irq}), 32'h3);
        @(posedge clk);
        rst <= 1'b1;
        repeat (6) @(posedge clk);
        rst <= 1'b0;
        t_reset_vals();
        end_sim();
    end
endmodule

`default_nettype wire
